// file: core/fbac_consts.vh
`ifndef FBAC_CONSTS_VH
`define FBAC_CONSTS_VH
// register byte offsets
`define FBAC_OFS_RED_PORT_RSV   8'h00
`define FBAC_OFS_PROC_PORT_RSV  8'h04
`define FBAC_OFS_UPL_PORT_RSV   8'h08
`define FBAC_OFS_SHARED_SIZE    8'h0C
`define FBAC_OFS_CLS1_RSV       8'h10
`define FBAC_OFS_CLS2_RSV       8'h14
`define FBAC_OFS_CLS3_RSV       8'h18
`define FBAC_OFS_XOFF_LEVEL     8'h1C
`define FBAC_OFS_LOW_THRESH     8'h20
`define FBAC_OFS_MC_THRESH      8'h24
`define FBAC_OFS_DROP_PROB      8'h28
`define FBAC_OFS_FC_ENABLE      8'h2C
`define FBAC_OFS_PRIO_MAP       8'h30
`define FBAC_OFS_PAUSE_STAT     8'h34
`define FBAC_OFS_SHARED_USED    8'h38
`define FBAC_OFS_MC_COUNT       8'h3C
`define FBAC_OFS_DROP_COUNT     8'h40
`define FBAC_OFS_TEMP_USED      8'h44
// reset values
`define FBAC_RST_PORT_RSV       16'h0010
`define FBAC_RST_SHARED_SIZE    16'h0040
`define FBAC_RST_CLS_RSV        16'h0008
`define FBAC_RST_XOFF_LEVEL     16'h000C
`define FBAC_RST_LOW_THRESH     16'h0004
`define FBAC_RST_MC_THRESH      16'h0020
`define FBAC_RST_DROP_PROB      8'h80
`define FBAC_RST_PRIO_MAP       24'h6D2240
// port numbering: indices 0..3 reduced ports, 4 uplink, 5 processor
`define FBAC_PROC_PORT_NUM      4'h8
`define FBAC_UPLINK_IDX         3'h4
`define FBAC_PROC_IDX           3'h5
// region codes
`define FBAC_RG_CLASS           2'h0
`define FBAC_RG_SHARED          2'h1
`define FBAC_RG_PORT            2'h2
`define FBAC_RG_NONE            2'h3
// axi responses
`define FBAC_RESP_OKAY          2'h0
`define FBAC_RESP_SLVERR        2'h2
`endif

// file: core/fbac_admission.v
// Contract
// - hold every arrival in temporary region first
// - three programmable class reservations, lowest none
// - sections cover priorities 2/3, 4/5, 6/7
// - account eight priority classes separately
// - six source port reservations, processor is 8
// - class section, then shared pool, then port
// - seven separately programmable section sizes
// - drop best effort lacking source port space
// - congested and shared exhausted: probabilistic drop
// - congested and port below low: drop
// - flow control port suppresses scarcity drops
// - pause on at programmed port usage
// - pause off once port reservation empty
// - multicast count threshold drives pause on/off
// - prioritise by map only on ports without flow control enabled
// - flow control enable, not the map, sends flow control traffic best effort
// - queue three expedited, two/one assured, zero best
// - best effort lowest; flow control ports best effort
// - priority frames drop only when resources exhausted
`timescale 1ns/100ps
`default_nettype none
`include "fbac_consts.vh"
module fbac_admission #(
  parameter CW = 16
) (
  input  wire        CLK,
  input  wire        SYS_RST,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [7:0]  S_AXI_AWADDR,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  output reg  [1:0]  S_AXI_BRESP,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  input  wire [7:0]  S_AXI_ARADDR,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  input  wire        RX_ARRIVE,
  input  wire [2:0]  RX_SRC_IDX,
  input  wire        CLS_VALID,
  input  wire [2:0]  CLS_SRC_IDX,
  input  wire [2:0]  CLS_PRIO,
  input  wire        CLS_MCAST,
  input  wire        CLS_CONGESTED,
  output reg         ADM_VALID,
  output reg         ADM_ACCEPT,
  output reg  [1:0]  ADM_REGION,
  output reg  [1:0]  ADM_QUEUE,
  output reg  [2:0]  ADM_PRIO,
  output reg  [2:0]  ADM_SRC_IDX,
  input  wire        REL_VALID,
  input  wire [1:0]  REL_REGION,
  input  wire [2:0]  REL_PRIO,
  input  wire [2:0]  REL_SRC_IDX,
  input  wire        REL_MCAST,
  output reg  [5:0]  PAUSE_ON,
  output reg  [5:0]  PAUSE_OFF,
  output reg         MC_PAUSE_ON,
  output reg         MC_PAUSE_OFF,
  output wire [3:0]  PROC_PORT_NUMBER
);
  reg [CW-1:0] red_rsv_reg, proc_rsv_reg, upl_rsv_reg, shared_size_reg;
  reg [CW-1:0] cls_rsv_reg [0:2];
  reg [CW-1:0] xoff_level_reg, low_thresh_reg, mc_thresh_reg;
  reg [7:0]    drop_prob_reg;
  reg [5:0]    fc_en_reg;
  reg [23:0]   prio_map_reg;
  reg [CW-1:0] cls_used_reg [0:7];
  reg [CW-1:0] port_used_reg [0:5];
  reg [CW-1:0] shared_used_reg, temp_used_reg, mc_count_reg, drop_count_reg;
  reg [5:0]    paused_reg;
  reg          mc_paused_reg;
  reg [15:0]   lfsr_reg;
  reg          aw_held_reg, w_held_reg;
  reg [7:0]    aw_addr_reg;
  reg [31:0]   w_data_reg;
  integer      i;

  assign PROC_PORT_NUMBER = `FBAC_PROC_PORT_NUM;

  function [1:0] sect_of;
    input [2:0] p;
    begin
      sect_of = p[2:1] - 2'h1;
    end
  endfunction

  function [CW-1:0] port_size;
    input [2:0] idx;
    begin
      if (idx == `FBAC_PROC_IDX)
        port_size = proc_rsv_reg;
      else if (idx == `FBAC_UPLINK_IDX)
        port_size = upl_rsv_reg;
      else
        port_size = red_rsv_reg;
    end
  endfunction

  // classification and admission decision (combinational)
  wire [2:0]    cp = CLS_PRIO;
  wire [1:0]    sect = sect_of(cp);
  wire          has_cls = cp[2] | cp[1];
  // both classes of a pair draw on one section, each counted apart
  wire [CW-1:0] sect_used = cls_used_reg[{cp[2:1], 1'b0}]
                          + cls_used_reg[{cp[2:1], 1'b1}];
  wire          cls_room = has_cls &&
                (sect_used < cls_rsv_reg[sect]);
  wire          sh_room = shared_used_reg < shared_size_reg;
  wire [CW-1:0] psize = port_size(CLS_SRC_IDX);
  wire [CW-1:0] pused = port_used_reg[CLS_SRC_IDX];
  wire          pt_room = pused < psize;
  wire          fc = fc_en_reg[CLS_SRC_IDX];
  // flow control ports forced to best effort, others via map
  wire [1:0]    mapq = prio_map_reg[cp*3 +: 2];
  wire [1:0]    queue = fc ? 2'h0 : mapq;
  wire          be = (queue == 2'h0);
  wire [CW-1:0] p_left = psize - pused;
  wire          rnd_hit = lfsr_reg[7:0] < drop_prob_reg;
  reg  [1:0]    region;
  reg           accept;
  always @* begin
    if (cls_room)
      region = `FBAC_RG_CLASS;
    else if (sh_room)
      region = `FBAC_RG_SHARED;
    else if (pt_room)
      region = `FBAC_RG_PORT;
    else
      region = `FBAC_RG_NONE;
    accept = (region != `FBAC_RG_NONE);
    if (be && !fc) begin
      if (!pt_room)
        accept = 1'b0;
      if (CLS_CONGESTED && !sh_room && rnd_hit)
        accept = 1'b0;
      if (CLS_CONGESTED && p_left < low_thresh_reg)
        accept = 1'b0;
    end
  end

  // axi-lite slave: address and data taken in either order
  wire aw_ok = aw_held_reg | S_AXI_AWVALID;
  wire w_ok  = w_held_reg | S_AXI_WVALID;
  wire wr_go = aw_ok && w_ok && !S_AXI_BVALID;
  wire [7:0]  wa = aw_held_reg ? aw_addr_reg : S_AXI_AWADDR;
  wire [31:0] wd = w_held_reg ? w_data_reg : S_AXI_WDATA;
  assign S_AXI_AWREADY = !aw_held_reg && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_held_reg && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  // byte strobes ignored: fields are written whole
  wire [CW-1:0] wv = wd[CW-1:0];

  reg [31:0] rd_next;
  reg        rd_err;
  always @* begin
    rd_next = 32'h0;
    rd_err = 1'b0;
    if (S_AXI_ARADDR == `FBAC_OFS_RED_PORT_RSV)
      rd_next[CW-1:0] = red_rsv_reg;
    else if (S_AXI_ARADDR == `FBAC_OFS_PROC_PORT_RSV)
      rd_next[CW-1:0] = proc_rsv_reg;
    else if (S_AXI_ARADDR == `FBAC_OFS_UPL_PORT_RSV)
      rd_next[CW-1:0] = upl_rsv_reg;
    else if (S_AXI_ARADDR == `FBAC_OFS_SHARED_SIZE)
      rd_next[CW-1:0] = shared_size_reg;
    else if (S_AXI_ARADDR == `FBAC_OFS_CLS1_RSV)
      rd_next[CW-1:0] = cls_rsv_reg[0];
    else if (S_AXI_ARADDR == `FBAC_OFS_CLS2_RSV)
      rd_next[CW-1:0] = cls_rsv_reg[1];
    else if (S_AXI_ARADDR == `FBAC_OFS_CLS3_RSV)
      rd_next[CW-1:0] = cls_rsv_reg[2];
    else if (S_AXI_ARADDR == `FBAC_OFS_XOFF_LEVEL)
      rd_next[CW-1:0] = xoff_level_reg;
    else if (S_AXI_ARADDR == `FBAC_OFS_LOW_THRESH)
      rd_next[CW-1:0] = low_thresh_reg;
    else if (S_AXI_ARADDR == `FBAC_OFS_MC_THRESH)
      rd_next[CW-1:0] = mc_thresh_reg;
    else if (S_AXI_ARADDR == `FBAC_OFS_DROP_PROB)
      rd_next[7:0] = drop_prob_reg;
    else if (S_AXI_ARADDR == `FBAC_OFS_FC_ENABLE)
      rd_next[5:0] = fc_en_reg;
    else if (S_AXI_ARADDR == `FBAC_OFS_PRIO_MAP)
      rd_next[23:0] = prio_map_reg;
    else if (S_AXI_ARADDR == `FBAC_OFS_PAUSE_STAT)
      rd_next[6:0] = {mc_paused_reg, paused_reg};
    else if (S_AXI_ARADDR == `FBAC_OFS_SHARED_USED)
      rd_next[CW-1:0] = shared_used_reg;
    else if (S_AXI_ARADDR == `FBAC_OFS_MC_COUNT)
      rd_next[CW-1:0] = mc_count_reg;
    else if (S_AXI_ARADDR == `FBAC_OFS_DROP_COUNT)
      rd_next[CW-1:0] = drop_count_reg;
    else if (S_AXI_ARADDR == `FBAC_OFS_TEMP_USED)
      rd_next[CW-1:0] = temp_used_reg;
    else
      rd_err = 1'b1;
  end

  reg wr_err;
  always @* begin
    wr_err = 1'b0;
    if (wa > `FBAC_OFS_PRIO_MAP || wa[1:0] != 2'h0)
      wr_err = 1'b1;
  end

  always @(posedge CLK) begin
    if (SYS_RST) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `FBAC_RESP_OKAY;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= `FBAC_RESP_OKAY;
      red_rsv_reg <= `FBAC_RST_PORT_RSV;
      proc_rsv_reg <= `FBAC_RST_PORT_RSV;
      upl_rsv_reg <= `FBAC_RST_PORT_RSV;
      shared_size_reg <= `FBAC_RST_SHARED_SIZE;
      for (i = 0; i < 3; i = i + 1)
        cls_rsv_reg[i] <= `FBAC_RST_CLS_RSV;
      xoff_level_reg <= `FBAC_RST_XOFF_LEVEL;
      low_thresh_reg <= `FBAC_RST_LOW_THRESH;
      mc_thresh_reg <= `FBAC_RST_MC_THRESH;
      drop_prob_reg <= `FBAC_RST_DROP_PROB;
      fc_en_reg <= 6'h00;
      prio_map_reg <= `FBAC_RST_PRIO_MAP;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY && !wr_go) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY && !wr_go) begin
        w_held_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_err ? `FBAC_RESP_SLVERR : `FBAC_RESP_OKAY;
        if (wa == `FBAC_OFS_RED_PORT_RSV)
          red_rsv_reg <= wv;
        else if (wa == `FBAC_OFS_PROC_PORT_RSV)
          proc_rsv_reg <= wv;
        else if (wa == `FBAC_OFS_UPL_PORT_RSV)
          upl_rsv_reg <= wv;
        else if (wa == `FBAC_OFS_SHARED_SIZE)
          shared_size_reg <= wv;
        else if (wa == `FBAC_OFS_CLS1_RSV)
          cls_rsv_reg[0] <= wv;
        else if (wa == `FBAC_OFS_CLS2_RSV)
          cls_rsv_reg[1] <= wv;
        else if (wa == `FBAC_OFS_CLS3_RSV)
          cls_rsv_reg[2] <= wv;
        else if (wa == `FBAC_OFS_XOFF_LEVEL)
          xoff_level_reg <= wv;
        else if (wa == `FBAC_OFS_LOW_THRESH)
          low_thresh_reg <= wv;
        else if (wa == `FBAC_OFS_MC_THRESH)
          mc_thresh_reg <= wv;
        else if (wa == `FBAC_OFS_DROP_PROB)
          drop_prob_reg <= wd[7:0];
        else if (wa == `FBAC_OFS_FC_ENABLE)
          fc_en_reg <= wd[5:0];
        else if (wa == `FBAC_OFS_PRIO_MAP)
          prio_map_reg <= wd[23:0];
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_next;
        S_AXI_RRESP <= rd_err ? `FBAC_RESP_SLVERR : `FBAC_RESP_OKAY;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // occupancy accounting; charge and release may meet in one cycle
  wire acc = CLS_VALID && accept;
  wire rel_cls = REL_VALID && REL_REGION == `FBAC_RG_CLASS;
  wire rel_sh  = REL_VALID && REL_REGION == `FBAC_RG_SHARED;
  wire rel_pt  = REL_VALID && REL_REGION == `FBAC_RG_PORT;
  wire [CW-1:0] one = {{(CW-1){1'b0}}, 1'b1};
  always @(posedge CLK) begin
    if (SYS_RST) begin
      for (i = 0; i < 8; i = i + 1)
        cls_used_reg[i] <= {CW{1'b0}};
      for (i = 0; i < 6; i = i + 1)
        port_used_reg[i] <= {CW{1'b0}};
      shared_used_reg <= {CW{1'b0}};
      temp_used_reg <= {CW{1'b0}};
      mc_count_reg <= {CW{1'b0}};
      drop_count_reg <= {CW{1'b0}};
      lfsr_reg <= 16'hACE1;
      ADM_VALID <= 1'b0;
      ADM_ACCEPT <= 1'b0;
      ADM_REGION <= `FBAC_RG_NONE;
      ADM_QUEUE <= 2'h0;
      ADM_PRIO <= 3'h0;
      ADM_SRC_IDX <= 3'h0;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^
                   lfsr_reg[12] ^ lfsr_reg[10]};
      // temporary region holds frame until classification resolves
      temp_used_reg <= temp_used_reg + (RX_ARRIVE ? one : {CW{1'b0}})
                       - (CLS_VALID ? one : {CW{1'b0}});
      ADM_VALID <= CLS_VALID;
      ADM_ACCEPT <= accept;
      ADM_REGION <= accept ? region : `FBAC_RG_NONE;
      ADM_QUEUE <= queue;
      ADM_PRIO <= cp;
      ADM_SRC_IDX <= CLS_SRC_IDX;
      if (CLS_VALID && !accept)
        drop_count_reg <= drop_count_reg + one;
      for (i = 0; i < 8; i = i + 1)
        cls_used_reg[i] <= cls_used_reg[i]
          + ((acc && region == `FBAC_RG_CLASS && cp == i) ? one : {CW{1'b0}})
          - ((rel_cls && REL_PRIO == i) ? one : {CW{1'b0}});
      for (i = 0; i < 6; i = i + 1)
        port_used_reg[i] <= port_used_reg[i]
          + ((acc && region == `FBAC_RG_PORT && CLS_SRC_IDX == i) ? one
             : {CW{1'b0}})
          - ((rel_pt && REL_SRC_IDX == i) ? one : {CW{1'b0}});
      shared_used_reg <= shared_used_reg
        + ((acc && region == `FBAC_RG_SHARED) ? one : {CW{1'b0}})
        - (rel_sh ? one : {CW{1'b0}});
      mc_count_reg <= mc_count_reg + ((acc && CLS_MCAST) ? one : {CW{1'b0}})
        - ((REL_VALID && REL_MCAST) ? one : {CW{1'b0}});
    end
  end

  // pause requests are one-cycle pulses on state change
  always @(posedge CLK) begin
    if (SYS_RST) begin
      paused_reg <= 6'h00;
      mc_paused_reg <= 1'b0;
      PAUSE_ON <= 6'h00;
      PAUSE_OFF <= 6'h00;
      MC_PAUSE_ON <= 1'b0;
      MC_PAUSE_OFF <= 1'b0;
    end else begin
      for (i = 0; i < 6; i = i + 1) begin
        PAUSE_ON[i] <= 1'b0;
        PAUSE_OFF[i] <= 1'b0;
        if (!paused_reg[i] && port_used_reg[i] >= xoff_level_reg) begin
          paused_reg[i] <= 1'b1;
          PAUSE_ON[i] <= 1'b1;
        end else if (paused_reg[i] && port_used_reg[i] == {CW{1'b0}}) begin
          paused_reg[i] <= 1'b0;
          PAUSE_OFF[i] <= 1'b1;
        end
      end
      MC_PAUSE_ON <= 1'b0;
      MC_PAUSE_OFF <= 1'b0;
      if (!mc_paused_reg && mc_count_reg > mc_thresh_reg) begin
        mc_paused_reg <= 1'b1;
        MC_PAUSE_ON <= 1'b1;
      end else if (mc_paused_reg && mc_count_reg < mc_thresh_reg) begin
        mc_paused_reg <= 1'b0;
        MC_PAUSE_OFF <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/fbac_admission_properties.sv
`timescale 1ns/100ps
`default_nettype none
module fbac_admission_properties (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       CLS_VALID,
  input wire logic [2:0] CLS_PRIO,
  input wire logic [2:0] CLS_SRC_IDX,
  input wire logic       ADM_VALID,
  input wire logic       ADM_ACCEPT,
  input wire logic [1:0] ADM_REGION,
  input wire logic [2:0] ADM_PRIO,
  input wire logic [2:0] ADM_SRC_IDX,
  input wire logic [5:0] PAUSE_ON,
  input wire logic       MC_PAUSE_ON,
  input wire logic       MC_PAUSE_OFF,
  input wire logic [3:0] PROC_PORT_NUMBER
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  chk_adm_answer: assert property (CLS_VALID |=> ADM_VALID)
    else $error("no admission answer");
  chk_adm_cause: assert property (ADM_VALID |-> $past(CLS_VALID))
    else $error("admission without classification");
  chk_class_echo: assert property (CLS_VALID |=>
    {ADM_PRIO, ADM_SRC_IDX} == $past({CLS_PRIO, CLS_SRC_IDX})) else $error("echo wrong");
  chk_drop_region: assert property (ADM_VALID |-> ADM_ACCEPT == (ADM_REGION != 2'h3))
    else $error("accept and region disagree");
  chk_low_class: assert property (ADM_VALID && ADM_PRIO < 3'h2 |-> ADM_REGION != 2'h0)
    else $error("low class got reservation");
  chk_pause_once: assert property ((PAUSE_ON & $past(PAUSE_ON)) == 6'h0)
    else $error("pause on longer than a pulse");
  chk_mc_pulse: assert property (MC_PAUSE_ON |=> !MC_PAUSE_ON && !MC_PAUSE_OFF)
    else $error("multicast pause toggled too fast");
  chk_proc_number: assert property (PROC_PORT_NUMBER == 4'h8)
    else $error("processor port number wrong");
endmodule
`default_nettype wire

// file: sim/fbac_far_end.sv
`timescale 1ns/100ps
`default_nettype none
module fbac_far_end (
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic       DRAIN,
  input  wire logic       CLS_VALID,
  input  wire logic       CLS_MCAST,
  input  wire logic       ADM_VALID,
  input  wire logic       ADM_ACCEPT,
  input  wire logic [1:0] ADM_REGION,
  input  wire logic [2:0] ADM_PRIO,
  input  wire logic [2:0] ADM_SRC_IDX,
  output var  logic       REL_VALID,
  output var  logic [1:0] REL_REGION,
  output var  logic [2:0] REL_PRIO,
  output var  logic [2:0] REL_SRC_IDX,
  output var  logic       REL_MCAST
);
  logic [8:0] held[$];
  logic       mc_reg;
  initial {REL_VALID, REL_MCAST, REL_REGION, REL_PRIO, REL_SRC_IDX} = 10'h0;
  // at most one release every other cycle, and none while stalled
  always @(posedge CLK) begin
    if (CLS_VALID) mc_reg <= CLS_MCAST;
    if (ADM_VALID && ADM_ACCEPT) held.push_back({mc_reg, ADM_REGION, ADM_PRIO, ADM_SRC_IDX});
    if (!SYS_RST && DRAIN && held.size() > 0 && !REL_VALID) begin
      {REL_MCAST, REL_REGION, REL_PRIO, REL_SRC_IDX} <= held.pop_front();
      REL_VALID <= 1'b1;
    end else begin
      REL_VALID <= 1'b0;
      // idle fields scrambled so stale values never look valid
      {REL_MCAST, REL_REGION, REL_PRIO, REL_SRC_IDX} <= ~{REL_MCAST, REL_REGION, REL_PRIO,
                                                          REL_SRC_IDX};
    end
    if (SYS_RST) held.delete();
  end
endmodule
`default_nettype wire

// file: sim/fbac_admission_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "fbac_consts.vh"
module fbac_admission_bench;
  logic CLK, SYS_RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, drain;
  logic RX_ARRIVE, CLS_VALID, CLS_MCAST, CLS_CONGESTED, ADM_VALID, ADM_ACCEPT;
  logic REL_VALID, REL_MCAST, MC_PAUSE_ON, MC_PAUSE_OFF;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, ADM_REGION, ADM_QUEUE, REL_REGION, rs;
  logic [2:0] RX_SRC_IDX, CLS_SRC_IDX, CLS_PRIO, ADM_PRIO, ADM_SRC_IDX, REL_PRIO, REL_SRC_IDX;
  logic [3:0] S_AXI_WSTRB, PROC_PORT_NUMBER;
  logic [5:0] PAUSE_ON, PAUSE_OFF, fc;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, q, seed = 32'h9D6515BD;
  logic [8:0] eq[$];
  logic [7:0] ca[10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h24, 8'h28};
  logic [31:0] cd[10] = '{32'h2, 32'h1, 32'h3, 32'h2, 32'h1, 32'h2, 32'h1, 32'h2, 32'h2, 32'h0};
  logic [31:0] rv[13] = '{32'h10, 32'h10, 32'h10, 32'h40, 32'h8, 32'h8, 32'h8, 32'hC, 32'h4,
                          32'h20, 32'h80, 32'h0, `FBAC_RST_PRIO_MAP};
  int fail_count, comparisons, pu[6], cu[3], su, mcn, drops, e_on, e_off, e_mon, e_moff;
  int o_on, o_off, o_mon, o_moff, i;
  bit pz[6], mcz;
  logic [23:0] pm = `FBAC_RST_PRIO_MAP;

  fbac_admission u_fbac_admission (.*);
  fbac_far_end u_fbac_far_end (.DRAIN(drain), .*);

  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  task automatic report_and_stop();
    if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int lim(input logic [2:0] s);
    return s < 4 ? 2 : s == 4 ? 3 : 1;
  endfunction

  // readiness sampled mid-cycle, where it equals its value at the next edge
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r, output logic [31:0] v);
    int n;
    bit ha, hw, hr;
    @(posedge CLK);
    if (w) begin
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    end else begin
      S_AXI_ARADDR <= a;
      {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    end
    for (n = 0; n < 64; n++) begin
      @(negedge CLK);
      ha = S_AXI_AWREADY & S_AXI_AWVALID | S_AXI_ARREADY & S_AXI_ARVALID;
      hw = S_AXI_WREADY & S_AXI_WVALID;
      hr = w ? S_AXI_BVALID : S_AXI_RVALID;
      r = w ? S_AXI_BRESP : S_AXI_RRESP;
      v = S_AXI_RDATA;
      @(posedge CLK);
      if (ha) {S_AXI_AWVALID, S_AXI_ARVALID} <= 2'h0;
      if (hw) S_AXI_WVALID <= 1'b0;
      if (hr) begin
        {S_AXI_BREADY, S_AXI_RREADY} <= 2'h0;
        break;
      end
    end
    if (n == 64) begin
      chk("bus_timeout", 1, 0);
      report_and_stop();
    end
  endtask

  task automatic adm(input logic [2:0] pr, s, input logic mc, cg);
    int c;
    logic [1:0] rg, qq;
    c = pr / 2 - 1;
    qq = fc[s] ? 2'h0 : pm[pr*3 +: 2];
    if (qq == 2'h0 && !fc[s] && (cg && lim(s) - pu[s] < 4 || pu[s] >= lim(s))) rg = 2'h3;
    else if (pr > 1 && cu[c] < (c == 1 ? 2 : 1)) rg = 2'h0;
    else if (su < 2) rg = 2'h1;
    else if (pu[s] < lim(s)) rg = 2'h2;
    else rg = 2'h3;
    @(posedge CLK);
    {RX_ARRIVE, RX_SRC_IDX} <= {1'b1, s};
    @(posedge CLK);
    RX_ARRIVE <= 1'b0;
    {CLS_VALID, CLS_PRIO, CLS_SRC_IDX, CLS_MCAST, CLS_CONGESTED} <= {1'b1, pr, s, mc, cg};
    @(posedge CLK);
    CLS_VALID <= 1'b0;
    @(negedge CLK);
    chk("adm_valid", ADM_VALID, 1);
    chk("adm_region", ADM_REGION, rg);
    chk("adm_accept", ADM_ACCEPT, rg != 2'h3);
    chk("adm_echo", {ADM_PRIO, ADM_SRC_IDX}, {pr, s});
    if (rg != 2'h3) chk("adm_queue", ADM_QUEUE, qq);
    case (rg)
      2'h0: cu[c]++;
      2'h1: su++;
      2'h2: pu[s]++;
      default: drops++;
    endcase
    if (pu[s] >= 2 && !pz[s]) {pz[s], e_on} = {1'b1, e_on + 1};
    if (rg != 2'h3) eq.push_back({mc, rg, pr, s});
    if (rg != 2'h3 && mc) mcn++;
    if (mcn > 2 && !mcz) {mcz, e_mon} = {1'b1, e_mon + 1};
  endtask

  // slot returns mirror the far end, which releases in admission order
  always @(posedge CLK) begin
    if (!SYS_RST) begin
      o_on += $countones(PAUSE_ON);
      o_off += $countones(PAUSE_OFF);
      o_mon += MC_PAUSE_ON;
      o_moff += MC_PAUSE_OFF;
    end
    if (REL_VALID === 1'b1) begin
      q = eq.pop_front();
      case (q[7:6])
        2'h0: cu[q[5:4] - 1]--;
        2'h1: su--;
        default: pu[q[2:0]]--;
      endcase
      if (pz[q[2:0]] && pu[q[2:0]] == 0) {pz[q[2:0]], e_off} = {1'b0, e_off + 1};
      if (q[8]) mcn--;
      if (mcz && mcn < 2) {mcz, e_moff} = {1'b0, e_moff + 1};
    end
  end

  task automatic drain_all();
    int n;
    drain <= 1'b1;
    for (n = 0; n < 500 && eq.size() > 0; n++) @(posedge CLK);
    drain <= 1'b0;
    repeat (4) @(posedge CLK);
    chk("drained", eq.size(), 0);
    bus(0, 8'h38, 0, rs, q);
    chk("shared_used", q, 0);
    chk("pause_off", o_off, e_off);
    chk("mc_off", o_moff, e_moff);
  endtask

  initial begin
    {SYS_RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 6'h20;
    {RX_ARRIVE, CLS_VALID, CLS_MCAST, CLS_CONGESTED, drain, fc} = 11'h0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = 52'hF;
    {RX_SRC_IDX, CLS_SRC_IDX, CLS_PRIO} = 9'h0;
    repeat (2) @(posedge CLK);
    SYS_RST <= 1'b0;
    chk("proc_num", PROC_PORT_NUMBER, 4'h8);
    for (i = 0; i < 13; i++) begin
      bus(0, 8'(4 * i), 0, rs, q);
      chk("reset_val", q, rv[i]);
    end
    for (i = 0; i < 10; i++) begin
      bus(1, ca[i], cd[i], rs, q);
      chk("wr_resp", rs, 2'h0);
      bus(0, ca[i], 0, rs, q);
      chk("readback", q, cd[i]);
    end
    bus(0, 8'h48, 0, rs, q);
    chk("bad_rd", {rs, q[29:0]}, 0 | 32'h80000000);
    bus(1, 8'h38, 32'h5, rs, q);
    chk("ro_wr", rs, 2'h2);
    @(posedge CLK);
    RX_ARRIVE <= 1'b1;
    @(posedge CLK);
    RX_ARRIVE <= 1'b0;
    bus(0, 8'h44, 0, rs, q);
    chk("temp_used", q, 1);
    adm(0, 1, 0, 0);
    adm(1, 1, 0, 0);
    adm(0, 0, 0, 1);
    adm(7, 2, 0, 0);
    bus(1, 8'h2C, 32'hF, rs, q);
    fc = 6'h0F;
    adm(0, 0, 0, 1);
    adm(6, 0, 1, 1);
    bus(1, 8'h30, 32'h0, rs, q);
    chk("map_wr", rs, 2'h0);
    pm = 24'h0;
    adm(6, 4, 0, 0);
    bus(1, 8'h30, `FBAC_RST_PRIO_MAP, rs, q);
    pm = `FBAC_RST_PRIO_MAP;
    repeat (2) begin
      for (i = 0; i < 24; i++) begin
        q = rnd();
        adm(q[2:0], q[5:3] % 3'h6, q[6], q[7]);
      end
      repeat (4) @(posedge CLK);
      chk("pause_on", o_on, e_on);
      chk("mc_on", o_mon, e_mon);
      drain_all();
    end
    bus(0, 8'h40, 0, rs, q);
    chk("drops", q, drops);
    report_and_stop();
  end
endmodule
bind fbac_admission fbac_admission_properties u_chk (.*);
`default_nettype wire
